/* File: design/i2sw_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "i2sw_defs.svh"
module i2sw_top #(parameter logic [4:0] fixed_addr = `I2SW_ADDR_HI_DEF) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic reset_pin_n,
  input wire logic addr_select_lo,
  input wire logic addr_select_hi,
  input wire logic chan0_irq_n,
  input wire logic chan1_irq_n,
  input wire logic chan2_irq_n,
  input wire logic chan3_irq_n,
  output logic irq_out_n,
  output logic chan0_enable,
  output logic chan1_enable,
  output logic chan2_enable,
  output logic chan3_enable,
  output i2sw_pkg::i2sw_nib_t downstream_clock_oe,
  output i2sw_pkg::i2sw_nib_t downstream_data_oe
);
  import i2sw_pkg::*;
  // ==========================================================
  // helpers
  // high when a level goes from low to high
  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction
  // ==========================================================
  // pin synchroniser
  i2sw_pins_t pins_raw; // pins as they arrive
  i2sw_pins_t pins_meta; // first stage, read only by second
  i2sw_pins_t pins; // second stage, safe to use
  logic scl_q; // previous sampled clock
  logic sda_q; // previous sampled data
  // gather the asynchronous pins
  always_comb begin
    pins_raw.irq_n = {chan3_irq_n, chan2_irq_n, chan1_irq_n,
                      chan0_irq_n};
    pins_raw.a_hi = addr_select_hi;
    pins_raw.a_lo = addr_select_lo;
    pins_raw.rst_n = reset_pin_n;
    pins_raw.sda = sda_in;
    pins_raw.scl = scl_in;
  end
  // two flip-flops on every pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= `I2SW_PINS_RST;
      pins <= `I2SW_PINS_RST;
    end else begin
      pins_meta <= pins_raw;
      pins <= pins_meta;
    end
  end
  // previous levels for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins.scl;
      sda_q <= pins.sda;
    end
  end
  // ==========================================================
  // bus conditions
  logic scl_rise; // sample point of a bit
  logic scl_fall; // change point of a bit
  logic start_c; // data falls while clock high
  logic stop_c; // data rises while clock high
  logic bus_rst; // reset pin held low
  logic [6:0] my_addr; // our seven-bit target address
  logic all_hi; // no channel interrupt present
  // edges are found by sampling, so a stopped clock is harmless
  assign scl_rise = rose(scl_q, pins.scl);
  assign scl_fall = rose(pins.scl, scl_q);
  assign start_c = pins.scl & scl_q & rose(pins.sda, sda_q);
  assign stop_c = pins.scl & scl_q & rose(sda_q, pins.sda);
  assign bus_rst = ~pins.rst_n;
  assign my_addr = {fixed_addr, pins.a_hi, pins.a_lo};
  assign all_hi = &pins.irq_n;
  // ==========================================================
  // serial state machine
  i2sw_state_t state; // protocol position
  logic [3:0] cnt; // bits seen in this byte
  logic [7:0] shift; // received byte
  logic [7:0] tx; // byte being sent
  logic rw; // direction from address lsb
  i2sw_nib_t sel; // applied channel selection
  i2sw_nib_t pend; // written, waiting for stop
  logic pend_v; // pend holds a byte
  logic [7:0] rd_byte; // byte offered on a read
  logic byte_wr; // a data byte completed
  logic addr_done; // an address byte completed
  assign rd_byte = {~pins.irq_n, sel};
  assign byte_wr = (state == ST_WRITE) & scl_fall & (cnt == `I2SW_BYTE_DONE);
  assign addr_done = (state == ST_ADDR) & scl_fall & (cnt == `I2SW_BYTE_DONE);
  // walk through address, acknowledge and data phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= `I2SW_CNT_RST;
      shift <= `I2SW_BYTE_RST;
      tx <= `I2SW_BYTE_RST;
      rw <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_rst) begin
      // reset pin: back to idle, let go of data
      state <= ST_IDLE;
      cnt <= `I2SW_CNT_RST;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      // start or repeated start
      state <= ST_ADDR;
      cnt <= `I2SW_CNT_RST;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: cnt <= `I2SW_CNT_RST;
        ST_ADDR, ST_WRITE: begin
          // shift in on rise, answer after eighth bit
          if (scl_rise) begin
            shift <= {shift[6:0], pins.sda};
            cnt <= cnt + `I2SW_CNT_STEP;
          end else if (addr_done) begin
            if (shift[7:1] == my_addr) begin
              rw <= shift[0];
              sda_oe <= 1'b1;
              state <= ST_ACK_ADDR;
            end else begin
              state <= ST_IDLE;
            end
          end else if (byte_wr) begin
            sda_oe <= 1'b1;
            state <= ST_ACK_WR;
          end
        end
        ST_ACK_ADDR: begin
          // end of address acknowledge
          if (scl_fall) begin
            cnt <= `I2SW_CNT_RST;
            if (rw) begin
              tx <= rd_byte;
              sda_oe <= ~rd_byte[7];
              state <= ST_READ;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_WRITE;
            end
          end
        end
        ST_ACK_WR: begin
          // end of data acknowledge, more bytes may follow
          if (scl_fall) begin
            sda_oe <= 1'b0;
            cnt <= `I2SW_CNT_RST;
            state <= ST_WRITE;
          end
        end
        ST_READ: begin
          // count on rise, present next bit on fall
          if (scl_rise) begin
            cnt <= cnt + `I2SW_CNT_STEP;
          end else if (scl_fall) begin
            if (cnt == `I2SW_BYTE_DONE) begin
              sda_oe <= 1'b0;
              state <= ST_ACK_RD;
            end else begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
            end
          end
        end
        ST_ACK_RD: begin
          // controller acknowledge: low asks for more
          if (scl_rise) begin
            state <= pins.sda ? ST_IDLE : ST_RD_NEXT;
          end
        end
        ST_RD_NEXT: begin
          // reload a fresh status byte
          if (scl_fall) begin
            cnt <= `I2SW_CNT_RST;
            tx <= rd_byte;
            sda_oe <= ~rd_byte[7];
            state <= ST_READ;
          end
        end
      endcase
    end
  end
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  // ==========================================================
  // control value and channel selection
  // hold written byte, apply it at stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= `I2SW_SEL_RST;
      pend <= `I2SW_SEL_RST;
      pend_v <= 1'b0;
    end else if (bus_rst) begin
      sel <= `I2SW_SEL_RST;
      pend_v <= 1'b0;
    end else if (stop_c) begin
      if (pend_v) begin
        sel <= pend;
      end
      pend_v <= 1'b0;
    end else if (byte_wr) begin
      pend <= shift[3:0];
      pend_v <= 1'b1;
    end
  end
  assign chan0_enable = sel[0];
  assign chan1_enable = sel[1];
  assign chan2_enable = sel[2];
  assign chan3_enable = sel[3];
  // mirror upstream lows onto the selected channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      downstream_clock_oe <= `I2SW_SEL_RST;
      downstream_data_oe <= `I2SW_SEL_RST;
    end else begin
      downstream_clock_oe <= sel & {4{~pins.scl}};
      downstream_data_oe <= sel & {4{~pins.sda}};
    end
  end
  // combined interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= all_hi;
    end
  end
  // ==========================================================
  // apb slave
  logic [`I2SW_EV_W-1:0] stat; // sticky events
  logic [`I2SW_EV_W-1:0] mask; // event enables
  logic [`I2SW_EV_W-1:0] ev; // events this cycle
  logic [`I2SW_EV_W-1:0] clr; // write-one-to-clear
  logic acc; // access phase, before answer
  logic wr_fire; // write completes
  logic [31:0] rdata; // read mux
  logic hit; // mapped address
  assign acc = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign ev[`I2SW_EV_APPLY] = stop_c & pend_v & ~bus_rst;
  assign ev[`I2SW_EV_IRQ] = irq_out_n & ~all_hi;
  assign clr = (wr_fire && paddr == `I2SW_STAT_OFS) ?
               pwdata[`I2SW_EV_W-1:0] : `I2SW_EV_RST;
  // read data and decode
  always_comb begin
    rdata = `I2SW_WORD_RST;
    hit = 1'b1;
    unique case (paddr)
      `I2SW_CTRL_OFS: begin
        rdata[7:0] = rd_byte;
        rdata[`I2SW_CW_PEND_HI:`I2SW_CW_PEND_LO] = pend;
        rdata[`I2SW_CW_PVAL] = pend_v;
        rdata[`I2SW_CW_BUSY] = (state != ST_IDLE);
      end
      `I2SW_STAT_OFS: rdata[`I2SW_EV_W-1:0] = stat;
      `I2SW_MASK_OFS: rdata[`I2SW_EV_W-1:0] = mask;
      default: hit = 1'b0;
    endcase
  end
  // one wait state, then answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= `I2SW_WORD_RST;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= pwrite ? `I2SW_WORD_RST : rdata;
        pslverr <= ~hit;
      end
    end
  end
  // sticky status, a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= `I2SW_EV_RST;
    end else begin
      stat <= (stat & ~clr) | ev;
    end
  end
  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= `I2SW_EV_RST;
    end else if (wr_fire && paddr == `I2SW_MASK_OFS) begin
      mask <= pwdata[`I2SW_EV_W-1:0];
    end
  end
  // level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end
  // ==========================================================
  // checks
  sel_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_rst |=> sel == `I2SW_SEL_RST && state == ST_IDLE)
    else $error("reset pin did not deselect");
  irq_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq_out_n == $past(all_hi))
    else $error("interrupt output not AND of inputs");
  stop_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    stop_c && pend_v && !bus_rst |=> sel == $past(pend))
    else $error("selection not applied at stop");
  hold_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    !stop_c && !bus_rst |=> sel == $past(sel))
    else $error("selection changed without stop");
  wr_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_wr && !bus_rst |=> pend_v && pend == $past(shift[3:0]))
    else $error("written byte not held");
  addr_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_done && !bus_rst && shift[7:1] == my_addr
    |=> sda_oe && state == ST_ACK_ADDR)
    else $error("own address not acknowledged");
  addr_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_done && !bus_rst && shift[7:1] != my_addr
    |=> !sda_oe && state == ST_IDLE)
    else $error("foreign address acknowledged");
  rd_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_ACK_ADDR && scl_fall && rw && !bus_rst
    |=> state == ST_READ && sda_oe == !$past(rd_byte[7]))
    else $error("read did not start with status msb");
  dn_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    pins.scl == 1'b0 ##1 1'b1
    |-> downstream_clock_oe == $past(sel))
    else $error("selected channels do not follow clock");
endmodule // i2sw_top
`default_nettype wire

/* File: design/i2sw_defs.svh */
`ifndef I2SW_DEFS_SVH
`define I2SW_DEFS_SVH
// ==========================================================
// register byte offsets
`define I2SW_CTRL_OFS 12'h000
`define I2SW_STAT_OFS 12'h004
`define I2SW_MASK_OFS 12'h008
// ==========================================================
// status and mask bits
`define I2SW_EV_APPLY 0
`define I2SW_EV_IRQ 1
`define I2SW_EV_W 2
`define I2SW_EV_RST 2'h0
// ==========================================================
// control word fields on the bus read
`define I2SW_CW_PEND_LO 8
`define I2SW_CW_PEND_HI 11
`define I2SW_CW_PVAL 12
`define I2SW_CW_BUSY 13
// ==========================================================
// serial side constants
`define I2SW_ADDR_HI_DEF 5'h0e
`define I2SW_BYTE_DONE 4'h8
`define I2SW_CNT_RST 4'h0
`define I2SW_CNT_STEP 4'h1
`define I2SW_SEL_RST 4'h0
`define I2SW_PINS_RST 9'h1ff
`define I2SW_WORD_RST 32'h0000_0000
`define I2SW_BYTE_RST 8'h00
`endif

/* File: design/i2sw_pkg.sv */
// ==========================================================
// types shared by the switch logic
package i2sw_pkg;
  // one bit per downstream channel
  typedef logic [3:0] i2sw_nib_t;
  // pin levels passing the synchroniser together
  typedef struct packed {
    logic [3:0] irq_n; // channel interrupt inputs
    logic a_hi; // address select high
    logic a_lo; // address select low
    logic rst_n; // reset pin
    logic sda; // upstream data
    logic scl; // upstream clock
  } i2sw_pins_t;
  // serial state machine
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WR,
    ST_READ, ST_ACK_RD, ST_RD_NEXT
  } i2sw_state_t;
endpackage

/* File: verif/i2sw_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// upstream two-wire controller, open drain on clock and data
module i2sw_ctl_model (
  output var logic scl_drv,
  output var logic sda_drv,
  input wire logic sda_line
);
  // both lines released: the clock stands high between frames
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // start: data falls while the clock is high
  task automatic start_c();
    sda_drv = 1'b1;
    #31 scl_drv = 1'b1;
    #31 sda_drv = 1'b0;
    #63 scl_drv = 1'b0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop_c();
    #31 sda_drv = 1'b0;
    #31 scl_drv = 1'b1;
    #63 sda_drv = 1'b1;
    #125;
  endtask
  // one 125 ns bit slot: data set mid-low, sampled mid-high
  task automatic bit_c(input logic b, output logic r);
    #31 sda_drv = b;
    #31 scl_drv = 1'b1;
    #31 r = sda_line;
    #32 scl_drv = 1'b0;
  endtask
  // byte sent msb first, then the target's acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], r);
    end
    bit_c(1'b1, r);
    ack = ~r;
  endtask
  // byte read with the data line released, then ack or nack
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, r);
      d[i] = r;
    end
    bit_c(nack, r);
  endtask
endmodule // i2sw_ctl_model
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// self-checking bench for the channel switch
module testbench;
  localparam logic [4:0] FIXED = 5'h0b; // non-default upper address
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, sda_out, sda_oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic rst_pin_n = 1'b1, a_lo = 1'b1, a_hi = 1'b0, irq_out_n, ack;
  logic [3:0] irq_n = 4'hf, en, dclk_oe, ddat_oe;
  logic scl, sda_drv, sda_line;
  logic [7:0] rd;
  int n_errors = 0, n_tests = 0;
  // open drain data line with pull-up
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  always #5 pclk = ~pclk;
  i2sw_ctl_model u_i2sw_ctl_model (.scl_drv(scl), .sda_drv(sda_drv),
    .sda_line(sda_line));
  i2sw_top #(.fixed_addr(FIXED)) u_i2sw_top (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .reset_pin_n(rst_pin_n),
    .addr_select_lo(a_lo), .addr_select_hi(a_hi),
    .chan0_irq_n(irq_n[0]), .chan1_irq_n(irq_n[1]),
    .chan2_irq_n(irq_n[2]), .chan3_irq_n(irq_n[3]),
    .irq_out_n(irq_out_n), .chan0_enable(en[0]), .chan1_enable(en[1]),
    .chan2_enable(en[2]), .chan3_enable(en[3]),
    .downstream_clock_oe(dclk_oe), .downstream_data_oe(ddat_oe));
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no time limit here: pready ends this wait, or the watchdog if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    ack = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // serial frame helpers: address byte, direction in the lsb
  task automatic addr_b(input logic rd_n);
    u_i2sw_ctl_model.start_c();
    u_i2sw_ctl_model.put_byte({FIXED, 2'b01, rd_n}, ack);
  endtask
  // idle state after reset, and an unmapped address
  task automatic s_reset();
    chk("enables", 4'h0, en);
    chk("int out", 1'b1, irq_out_n);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, q);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", 1'b1, ack);
  endtask
  // two bytes, last one wins, applied at stop only
  task automatic s_write();
    addr_b(1'b0);
    chk("addr ack", 1'b1, ack);
    u_i2sw_ctl_model.put_byte(8'h0a, ack);
    u_i2sw_ctl_model.put_byte(8'h05, ack);
    chk("data ack", 1'b1, ack);
    repeat (10) @(posedge pclk);
    chk("pre stop", 4'h0, en);
    u_i2sw_ctl_model.stop_c();
    repeat (4) @(posedge pclk);
    chk("applied", 4'h5, en);
    chk("clk oe", 4'h0, dclk_oe);
    apb(1'b1, 12'h008, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq set", 1'b1, irq);
    apb(1'b1, 12'h004, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq clr", 1'b0, irq);
  endtask
  // foreign address is not acknowledged
  task automatic s_addr();
    a_hi <= 1'b1;
    repeat (4) @(posedge pclk);
    addr_b(1'b0);
    chk("foreign", 1'b0, ack);
    u_i2sw_ctl_model.stop_c();
    @(posedge pclk);
    a_hi <= 1'b0;
  endtask
  // channel interrupt shows on the output and on a read
  task automatic s_int();
    irq_n <= 4'b1101;
    repeat (6) @(posedge pclk);
    chk("int out", 1'b0, irq_out_n);
    addr_b(1'b1);
    chk("rd ack", 1'b1, ack);
    // clock held low while the first zero bit is pulled down
    repeat (10) @(posedge pclk);
    chk("clk oe", 4'h5, dclk_oe);
    chk("dat oe", 4'h5, ddat_oe);
    u_i2sw_ctl_model.get_byte(1'b1, rd);
    u_i2sw_ctl_model.stop_c();
    chk("rd byte", 8'h25, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("stat", 32'h2, q & 32'h2);
    irq_n <= 4'hf;
  endtask
  // reset pin deselects every channel
  task automatic s_rstpin();
    rst_pin_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("pin rst", 4'h0, en);
    rst_pin_n <= 1'b1;
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_write();
    s_addr();
    s_int();
    s_rstpin();
    tally_and_finish();
  end
  // watchdog against a hang
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
